// [logic/dsp_decode_defines.svh]
// Opcode patterns, field positions and counts for the multiply/move decoder
// Functional notes
// RQ1: Pointer multiply with long immediate: two cycles, two words
// RQ2: Direct-address multiply: one cycle, two-bit operation
// RQ3: Pointer multiply-subtract takes immediate from second word
// RQ4: Register move: upper field destination, lower source
// RQ5: Register load from following long immediate word
// RQ6: Accumulator load from absolute address in word two
// RQ7: Accumulator low part stored to absolute address
// RQ8: Immediate shift: six-bit amount, source, destination fields
// RQ9: Exact tabulated cycles and words per instruction
// RQ10: Accumulator-select bit picks one of two accumulators
`ifndef DSP_DECODE_DEFINES_SVH
`define DSP_DECODE_DEFINES_SVH

// Opcode masks and match values
`define MUL_PTR_IMM_MASK   16'hF0E0
`define MUL_PTR_IMM_VAL    16'h8000
`define MUL_DIRECT_MASK    16'hF100
`define MUL_DIRECT_VAL     16'hE000
`define MSU_PTR_IMM_MASK   16'hFEE0
`define MSU_PTR_IMM_VAL    16'h90C0
`define MOV_REG_REG_MASK   16'hFC00
`define MOV_REG_REG_VAL    16'h5800
`define MOV_IMM_REG_MASK   16'hFEE0
`define MOV_IMM_REG_VAL    16'h5E00
`define ACC_ABS_MASK       16'hFEFF
`define LOAD_ACC_ABS_VAL   16'hD4B8
`define STORE_ACC_ABS_VAL  16'hD4BC
`define SHIFT_IMM_MASK     16'hF240
`define SHIFT_IMM_VAL      16'h9240

// Field positions
`define ACC_SEL_WIDE_BIT   11
`define ACC_SEL_NARROW_BIT 8
`define MUL_OP_HI          10
`define MUL_OP_LO          8
`define MUL_DIR_OP_HI      10
`define MUL_DIR_OP_LO      9
`define PTR_MOD_HI         4
`define PTR_MOD_LO         3
`define PTR_SEL_HI         2
`define PTR_SEL_LO         0
`define DIRECT_HI          7
`define DIRECT_LO          0
`define REG_DST_HI         9
`define REG_DST_LO         5
`define REG_SRC_HI         4
`define REG_SRC_LO         0
`define SHIFT_SRC_HI       11
`define SHIFT_SRC_LO       10
`define SHIFT_DST_HI       8
`define SHIFT_DST_LO       7
`define SHIFT_AMT_HI       5
`define SHIFT_AMT_LO       0

// Three-bit multiply operation codes; the direct multiply maps onto the first four
`define MUL_OP_MPY         3'h0
`define MUL_OP_MAC         3'h2
`define MUL_OP_MAA         3'h4
`define MUL_OP_MACSU       3'h6
`define MUL_OP_SUB         3'h7

// Cycle and word counts, zero word and direct-address pad
`define COUNT_ONE          2'h1
`define COUNT_TWO          2'h2
`define COUNT_ZERO         2'h0
`define WORD_ZERO          16'h0000
`define DIRECT_PAD         8'h00

`endif

// [logic/dsp_decode_pkg.sv]
// Types shared by the multiply/move decoder
package dsp_decode_pkg;
    // Decoded instruction class
    typedef enum logic [3:0] {
        OPC_NONE,
        OPC_MUL_PTR_IMM,
        OPC_MUL_DIRECT,
        OPC_MSU_PTR_IMM,
        OPC_MOV_REG_REG,
        OPC_MOV_IMM_REG,
        OPC_LOAD_ACC_ABS,
        OPC_STORE_ACC_ABS,
        OPC_SHIFT_IMM
    } op_class_t;

    // Sequencer state
    typedef enum logic {
        ST_IDLE,
        ST_WAIT_EXT
    } dec_state_t;
endpackage

// [logic/first_word_hold.sv]
// Holds the first word of a two-word instruction until its extension arrives
`include "dsp_decode_defines.svh"
module first_word_hold (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // Capture side
    input  wire logic        load_in,
    input  wire logic [15:0] word_in,
    // Held word
    output logic      [15:0] held_out
);
    // Capture on load, clear on reset
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            held_out <= `WORD_ZERO;
        end else if (load_in) begin
            held_out <= word_in;
        end
    end
endmodule // first_word_hold

// [logic/dsp_multiply_move_decoder.sv]
// Decoder for multiply, multiply-subtract, immediate shift and move encodings
`include "dsp_decode_defines.svh"
module dsp_multiply_move_decoder (
    // Clock and reset
    input  wire logic                      mclk_in,
    input  wire logic                      reset_in,
    // Fetched instruction words
    input  wire logic                      word_valid_in,
    input  wire logic [15:0]               word_in,
    // Issue strobe and status
    output logic                           issue_out,
    output logic                           unsupported_out,
    output logic                           busy_out,
    output dsp_decode_pkg::op_class_t      op_class_out,
    output logic [1:0]                     cycles_out,
    output logic [1:0]                     words_out,
    // Operand selects
    output logic                           primary_accumulator_sel_out,
    output logic [2:0]                     mul_op_out,
    output logic [2:0]                     pointer_register_sel_out,
    output logic [1:0]                     pointer_modify_out,
    output logic [4:0]                     dst_reg_out,
    output logic [4:0]                     src_reg_out,
    output logic [1:0]                     shift_src_out,
    output logic [1:0]                     shift_dst_out,
    output logic [5:0]                     shift_amount_out,
    // Immediate and address operands
    output logic [15:0]                    imm_out,
    output logic [15:0]                    direct_addr_out
);
    dsp_decode_pkg::dec_state_t state;       // Sequencer state
    dsp_decode_pkg::op_class_t  pend_class;  // Class awaiting extension word
    dsp_decode_pkg::op_class_t  cls_now;     // Class of the word on the input
    logic [15:0]                held_word;   // First word of a pending pair
    logic                       take_first;  // First word taken this cycle
    logic                       take_ext;    // Extension word taken this cycle

    // Classify one instruction word
    function automatic dsp_decode_pkg::op_class_t classify(input logic [15:0] w);
        if ((w & `MUL_PTR_IMM_MASK) == `MUL_PTR_IMM_VAL) begin
            classify = dsp_decode_pkg::OPC_MUL_PTR_IMM;
        end else if ((w & `MUL_DIRECT_MASK) == `MUL_DIRECT_VAL) begin
            classify = dsp_decode_pkg::OPC_MUL_DIRECT;
        end else if ((w & `MSU_PTR_IMM_MASK) == `MSU_PTR_IMM_VAL) begin
            classify = dsp_decode_pkg::OPC_MSU_PTR_IMM;
        end else if ((w & `MOV_REG_REG_MASK) == `MOV_REG_REG_VAL) begin
            classify = dsp_decode_pkg::OPC_MOV_REG_REG;
        end else if ((w & `MOV_IMM_REG_MASK) == `MOV_IMM_REG_VAL) begin
            classify = dsp_decode_pkg::OPC_MOV_IMM_REG;
        end else if ((w & `ACC_ABS_MASK) == `LOAD_ACC_ABS_VAL) begin
            classify = dsp_decode_pkg::OPC_LOAD_ACC_ABS;
        end else if ((w & `ACC_ABS_MASK) == `STORE_ACC_ABS_VAL) begin
            classify = dsp_decode_pkg::OPC_STORE_ACC_ABS;
        end else if ((w & `SHIFT_IMM_MASK) == `SHIFT_IMM_VAL) begin
            classify = dsp_decode_pkg::OPC_SHIFT_IMM;
        end else begin
            classify = dsp_decode_pkg::OPC_NONE;
        end
    endfunction

    // Classes that need a second program word
    function automatic logic two_words(input dsp_decode_pkg::op_class_t c);
        two_words = (c == dsp_decode_pkg::OPC_MUL_PTR_IMM)  ||
                    (c == dsp_decode_pkg::OPC_MSU_PTR_IMM)  ||
                    (c == dsp_decode_pkg::OPC_MOV_IMM_REG)  ||
                    (c == dsp_decode_pkg::OPC_LOAD_ACC_ABS) ||
                    (c == dsp_decode_pkg::OPC_STORE_ACC_ABS);
    endfunction

    // Map the two-bit direct multiply field onto the three-bit codes
    function automatic logic [2:0] direct_mul_op(input logic [1:0] f);
        case (f)
            2'h0:    direct_mul_op = `MUL_OP_MPY;
            2'h1:    direct_mul_op = `MUL_OP_MAC;
            2'h2:    direct_mul_op = `MUL_OP_MAA;
            default: direct_mul_op = `MUL_OP_MACSU;
        endcase
    endfunction

    assign cls_now    = classify(word_in);
    assign take_first = (state == dsp_decode_pkg::ST_IDLE) && word_valid_in;
    assign take_ext   = (state == dsp_decode_pkg::ST_WAIT_EXT) && word_valid_in;

    // First word kept for the extension cycle
    first_word_hold u_first_word_hold (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .load_in  (take_first),
        .word_in  (word_in),
        .held_out (held_word)
    );

    // Sequencer: a two-word class waits for the extension word
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state <= dsp_decode_pkg::ST_IDLE;
        end else begin
            case (state)
                dsp_decode_pkg::ST_IDLE: begin
                    if (word_valid_in && two_words(cls_now)) begin
                        state <= dsp_decode_pkg::ST_WAIT_EXT; // RQ9
                    end
                end
                default: begin
                    if (word_valid_in) begin
                        state <= dsp_decode_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Pending class for the extension cycle
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pend_class <= dsp_decode_pkg::OPC_NONE;
        end else if (take_first) begin
            pend_class <= cls_now;
        end
    end

    // Busy while a pair is incomplete
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            busy_out <= 1'b0;
        end else if (take_first) begin
            busy_out <= two_words(cls_now);
        end else if (take_ext) begin
            busy_out <= 1'b0;
        end
    end

    // Issue strobe, class, counts and operand fields
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            issue_out                   <= 1'b0;
            unsupported_out             <= 1'b0;
            op_class_out                <= dsp_decode_pkg::OPC_NONE;
            cycles_out                  <= `COUNT_ZERO;
            words_out                   <= `COUNT_ZERO;
            primary_accumulator_sel_out <= 1'b0;
            mul_op_out                  <= `MUL_OP_MPY;
            pointer_register_sel_out    <= 3'h0;
            pointer_modify_out          <= 2'h0;
            dst_reg_out                 <= 5'h00;
            src_reg_out                 <= 5'h00;
            shift_src_out               <= 2'h0;
            shift_dst_out               <= 2'h0;
            shift_amount_out            <= 6'h00;
            imm_out                     <= `WORD_ZERO;
            direct_addr_out             <= `WORD_ZERO;
        end else begin
            issue_out       <= 1'b0;
            unsupported_out <= 1'b0;
            if (take_first) begin
                // Words outside this group are flagged and not issued
                unsupported_out <= (cls_now == dsp_decode_pkg::OPC_NONE);
                issue_out       <= (cls_now != dsp_decode_pkg::OPC_NONE) && !two_words(cls_now);
                op_class_out    <= cls_now;
                cycles_out      <= two_words(cls_now) ? `COUNT_TWO : `COUNT_ONE; // RQ9
                words_out       <= two_words(cls_now) ? `COUNT_TWO : `COUNT_ONE; // RQ9
                case (cls_now)
                    dsp_decode_pkg::OPC_MUL_PTR_IMM: begin
                        primary_accumulator_sel_out <= word_in[`ACC_SEL_WIDE_BIT]; // RQ10
                        mul_op_out               <= word_in[`MUL_OP_HI:`MUL_OP_LO]; // RQ1
                        pointer_modify_out       <= word_in[`PTR_MOD_HI:`PTR_MOD_LO];
                        pointer_register_sel_out <= word_in[`PTR_SEL_HI:`PTR_SEL_LO];
                    end
                    dsp_decode_pkg::OPC_MUL_DIRECT: begin
                        primary_accumulator_sel_out <= word_in[`ACC_SEL_WIDE_BIT]; // RQ10
                        mul_op_out      <= direct_mul_op(word_in[`MUL_DIR_OP_HI:`MUL_DIR_OP_LO]); // RQ2
                        direct_addr_out <= {`DIRECT_PAD, word_in[`DIRECT_HI:`DIRECT_LO]}; // RQ2
                    end
                    dsp_decode_pkg::OPC_MSU_PTR_IMM: begin
                        primary_accumulator_sel_out <= word_in[`ACC_SEL_NARROW_BIT]; // RQ10
                        mul_op_out               <= `MUL_OP_SUB; // RQ3
                        pointer_modify_out       <= word_in[`PTR_MOD_HI:`PTR_MOD_LO];
                        pointer_register_sel_out <= word_in[`PTR_SEL_HI:`PTR_SEL_LO];
                    end
                    dsp_decode_pkg::OPC_MOV_REG_REG: begin
                        dst_reg_out <= word_in[`REG_DST_HI:`REG_DST_LO]; // RQ4
                        src_reg_out <= word_in[`REG_SRC_HI:`REG_SRC_LO]; // RQ4
                    end
                    dsp_decode_pkg::OPC_MOV_IMM_REG: begin
                        dst_reg_out <= word_in[`REG_SRC_HI:`REG_SRC_LO]; // RQ5
                    end
                    dsp_decode_pkg::OPC_LOAD_ACC_ABS,
                    dsp_decode_pkg::OPC_STORE_ACC_ABS: begin
                        primary_accumulator_sel_out <= word_in[`ACC_SEL_NARROW_BIT]; // RQ10
                    end
                    dsp_decode_pkg::OPC_SHIFT_IMM: begin
                        shift_src_out    <= word_in[`SHIFT_SRC_HI:`SHIFT_SRC_LO]; // RQ8
                        shift_dst_out    <= word_in[`SHIFT_DST_HI:`SHIFT_DST_LO]; // RQ8
                        shift_amount_out <= word_in[`SHIFT_AMT_HI:`SHIFT_AMT_LO]; // RQ8
                    end
                    default: begin
                        // Nothing to select for unsupported words
                    end
                endcase
            end else if (take_ext) begin
                // Second word completes the instruction
                issue_out <= 1'b1; // RQ9
                // Class is taken again from the held first word
                case (classify(held_word))
                    dsp_decode_pkg::OPC_LOAD_ACC_ABS,
                    dsp_decode_pkg::OPC_STORE_ACC_ABS: begin
                        direct_addr_out <= word_in; // RQ6 RQ7
                    end
                    default: begin
                        imm_out <= word_in; // RQ1 RQ3 RQ5
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    AST_MUL_PTR_TWO: assert property ( // RQ1
        issue_out && op_class_out == dsp_decode_pkg::OPC_MUL_PTR_IMM
        |-> cycles_out == `COUNT_TWO && words_out == `COUNT_TWO)
        else $error("pointer multiply not two cycles and words");
    AST_MUL_DIRECT_ONE: assert property ( // RQ2
        take_first && cls_now == dsp_decode_pkg::OPC_MUL_DIRECT
        |=> issue_out && words_out == `COUNT_ONE
            && direct_addr_out[`DIRECT_HI:`DIRECT_LO] == $past(word_in[`DIRECT_HI:`DIRECT_LO]))
        else $error("direct multiply not issued next cycle");
    AST_MSU_IMM: assert property ( // RQ3
        take_ext && pend_class == dsp_decode_pkg::OPC_MSU_PTR_IMM
        |=> issue_out && imm_out == $past(word_in) && mul_op_out == `MUL_OP_SUB)
        else $error("multiply-subtract immediate not from second word");
    AST_MOV_FIELDS: assert property ( // RQ4
        take_first && cls_now == dsp_decode_pkg::OPC_MOV_REG_REG
        |=> dst_reg_out == $past(word_in[`REG_DST_HI:`REG_DST_LO])
            && src_reg_out == $past(word_in[`REG_SRC_HI:`REG_SRC_LO]))
        else $error("register move fields swapped");
    AST_MOV_IMM_WAIT: assert property ( // RQ5
        take_first && cls_now == dsp_decode_pkg::OPC_MOV_IMM_REG
        |=> busy_out && !issue_out)
        else $error("long immediate load issued without its second word");
    AST_LOAD_ADDR: assert property ( // RQ6
        take_ext && pend_class == dsp_decode_pkg::OPC_LOAD_ACC_ABS
        |=> issue_out && direct_addr_out == $past(word_in))
        else $error("accumulator load address not from second word");
    AST_STORE_ADDR: assert property ( // RQ7
        take_ext && pend_class == dsp_decode_pkg::OPC_STORE_ACC_ABS
        |=> issue_out && direct_addr_out == $past(word_in) && !busy_out)
        else $error("accumulator store address not from second word");
    AST_SHIFT_AMT: assert property ( // RQ8
        take_first && cls_now == dsp_decode_pkg::OPC_SHIFT_IMM
        |=> issue_out && shift_amount_out == $past(word_in[`SHIFT_AMT_HI:`SHIFT_AMT_LO]))
        else $error("shift amount not taken from immediate field");
    AST_TWO_WORD_BUSY: assert property ( // RQ9
        issue_out && words_out == `COUNT_TWO
        |-> $past(busy_out))
        else $error("two-word instruction issued without extension wait");
    AST_ACC_SEL: assert property ( // RQ10
        take_first && cls_now == dsp_decode_pkg::OPC_MUL_DIRECT
        |=> primary_accumulator_sel_out == $past(word_in[`ACC_SEL_WIDE_BIT]))
        else $error("accumulator select bit not honoured");

    COV_ONE_WORD: cover property (take_first && cls_now == dsp_decode_pkg::OPC_MOV_REG_REG ##1 issue_out);
    COV_TWO_WORD: cover property (take_first && two_words(cls_now) ##[1:4] issue_out);
    COV_UNSUPPORTED: cover property (unsupported_out);
endmodule // dsp_multiply_move_decoder

// [sim/test_dsp_multiply_move_decoder.sv]
// Self-checking testbench for the multiply/move instruction decoder
module test_dsp_multiply_move_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and fetch side
    logic                      mclk_in;
    logic                      reset_in;
    logic                      word_valid_in;
    logic [15:0]               word_in;
    // Decoder outputs
    logic                      issue_out;
    logic                      unsupported_out;
    logic                      busy_out;
    dsp_decode_pkg::op_class_t op_class_out;
    logic [1:0]                cycles_out;
    logic [1:0]                words_out;
    logic                      primary_accumulator_sel_out;
    logic [2:0]                mul_op_out;
    logic [2:0]                pointer_register_sel_out;
    logic [1:0]                pointer_modify_out;
    logic [4:0]                dst_reg_out;
    logic [4:0]                src_reg_out;
    logic [1:0]                shift_src_out;
    logic [1:0]                shift_dst_out;
    logic [5:0]                shift_amount_out;
    logic [15:0]               imm_out;
    logic [15:0]               direct_addr_out;
    // Score keeping
    int                        error_cnt;
    int                        n_compared;

    // Device under test
    dsp_multiply_move_decoder u_dut (
        .mclk_in(mclk_in), .reset_in(reset_in),
        .word_valid_in(word_valid_in), .word_in(word_in),
        .issue_out(issue_out), .unsupported_out(unsupported_out), .busy_out(busy_out),
        .op_class_out(op_class_out), .cycles_out(cycles_out), .words_out(words_out),
        .primary_accumulator_sel_out(primary_accumulator_sel_out),
        .mul_op_out(mul_op_out), .pointer_register_sel_out(pointer_register_sel_out),
        .pointer_modify_out(pointer_modify_out), .dst_reg_out(dst_reg_out),
        .src_reg_out(src_reg_out), .shift_src_out(shift_src_out),
        .shift_dst_out(shift_dst_out), .shift_amount_out(shift_amount_out),
        .imm_out(imm_out), .direct_addr_out(direct_addr_out)
    );

    // 40 MHz core clock
    always #12.5 mclk_in = ~mclk_in;

    // Compare one value and count it
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Single-word instruction: issue pulse one cycle after the word
    task automatic one_word(input logic [15:0] w, input dsp_decode_pkg::op_class_t cls);
        @(negedge mclk_in);
        word_valid_in = 1'b1;
        word_in       = w;
        @(negedge mclk_in);
        word_valid_in = 1'b0;
        word_in       = ~w;                       // Stale bus must not matter
        chk(16'(issue_out), 16'h0001);
        chk(16'(busy_out), 16'h0000);
        chk(16'(op_class_out), 16'(cls));
        chk(16'(cycles_out), 16'h0001);
        chk(16'(words_out), 16'h0001);
    endtask

    // Two-word instruction: busy after word one, issue after word two
    task automatic two_word(input logic [15:0] w, input logic [15:0] ext,
                            input dsp_decode_pkg::op_class_t cls);
        @(negedge mclk_in);
        word_valid_in = 1'b1;
        word_in       = w;
        @(negedge mclk_in);
        chk(16'(busy_out), 16'h0001);
        chk(16'(issue_out), 16'h0000);
        chk(16'(cycles_out), 16'h0002);
        chk(16'(words_out), 16'h0002);
        word_in = ext;
        @(negedge mclk_in);
        word_valid_in = 1'b0;
        word_in       = ~ext;
        chk(16'(issue_out), 16'h0001);
        chk(16'(busy_out), 16'h0000);
        chk(16'(op_class_out), 16'(cls));
    endtask

    // Register move at field extremes
    task automatic t_mov();
        logic [4:0] d;
        logic [4:0] s;
        for (int i = 0; i < 2; i++) begin
            d = i ? 5'h00 : 5'h1F;
            s = ~d;                               // Source is the inverse, kept at 5 bits
            one_word(16'h5800 | (16'(d) << 5) | 16'(s), dsp_decode_pkg::OPC_MOV_REG_REG);
            chk(16'(dst_reg_out), 16'(d));
            chk(16'(src_reg_out), 16'(s));
        end
        @(negedge mclk_in);
        chk(16'(issue_out), 16'h0000);
    endtask

    // Accumulator load and store through an absolute address, both selects
    task automatic t_acc();
        for (int a = 0; a < 2; a++) begin
            two_word(16'hD4B8 | 16'(a << 8), 16'hA55A ^ 16'(a), dsp_decode_pkg::OPC_LOAD_ACC_ABS);
            chk(direct_addr_out, 16'hA55A ^ 16'(a));
            chk(16'(primary_accumulator_sel_out), 16'(a));
            two_word(16'hD4BC | 16'(a << 8), 16'h5AA5 ^ 16'(a), dsp_decode_pkg::OPC_STORE_ACC_ABS);
            chk(direct_addr_out, 16'h5AA5 ^ 16'(a));
            chk(16'(primary_accumulator_sel_out), 16'(a));
        end
    endtask

    // Pointer multiply with long immediate, every operation code
    task automatic t_mul_ptr();
        for (int op = 0; op < 8; op++) begin
            two_word(16'h8000 | 16'((op & 1) << 11) | 16'(op << 8) | 16'((op & 3) << 3)
                     | 16'(7 - op), 16'h1234 + 16'(op), dsp_decode_pkg::OPC_MUL_PTR_IMM);
            chk(imm_out, 16'h1234 + 16'(op));
            chk(16'(mul_op_out), 16'(op));
            chk(16'(pointer_register_sel_out), 16'(7 - op));
            chk(16'(pointer_modify_out), 16'(op & 3));
            chk(16'(primary_accumulator_sel_out), 16'(op & 1));
        end
    endtask

    // Direct-address multiply, every two-bit operation
    task automatic t_mul_dir();
        for (int x = 0; x < 4; x++) begin
            one_word(16'hE000 | 16'((x >> 1) << 11) | 16'(x << 9) | 16'h0080 | 16'(x),
                     dsp_decode_pkg::OPC_MUL_DIRECT);
            chk(16'(mul_op_out), 16'(x * 2));
            chk(direct_addr_out, 16'h0080 | 16'(x));
            chk(16'(primary_accumulator_sel_out), 16'(x >> 1));
        end
    endtask

    // Multiply-subtract with long immediate, both selects
    task automatic t_msu();
        for (int a = 0; a < 2; a++) begin
            two_word(16'h90C0 | 16'(a << 8) | 16'h0018 | 16'h0005, 16'hFFFF - 16'(a),
                     dsp_decode_pkg::OPC_MSU_PTR_IMM);
            chk(imm_out, 16'hFFFF - 16'(a));
            chk(16'(mul_op_out), 16'h0007);
            chk(16'(pointer_register_sel_out), 16'h0005);
            chk(16'(pointer_modify_out), 16'h0003);
            chk(16'(primary_accumulator_sel_out), 16'(a));
        end
    endtask

    // Register load from long immediate, free bit both ways
    task automatic t_limm();
        for (int b = 0; b < 2; b++) begin
            two_word(16'h5E00 | 16'(b << 8) | 16'(31 - b * 31), 16'h8001 ^ 16'(b),
                     dsp_decode_pkg::OPC_MOV_IMM_REG);
            chk(16'(dst_reg_out), 16'(31 - b * 31));
            chk(imm_out, 16'h8001 ^ 16'(b));
        end
    endtask

    // Immediate shift over source and destination extremes and the largest amount
    task automatic t_shift();
        logic [5:0] amt;
        for (int i = 0; i < 4; i++) begin
            amt = (i == 0) ? 6'h3F : 6'(i * 9);
            one_word(16'h9240 | 16'(i << 10) | 16'((3 - i) << 7) | 16'(amt),
                     dsp_decode_pkg::OPC_SHIFT_IMM);
            chk(16'(shift_src_out), 16'(i));
            chk(16'(shift_dst_out), 16'(3 - i));
            chk(16'(shift_amount_out), 16'(amt));
        end
    endtask

    // Word outside the group is flagged and never issued
    task automatic t_unsup();
        @(negedge mclk_in);
        word_valid_in = 1'b1;
        word_in       = 16'h0000;
        @(negedge mclk_in);
        word_valid_in = 1'b0;
        chk(16'(unsupported_out), 16'h0001);
        chk(16'(issue_out), 16'h0000);
        chk(16'(busy_out), 16'h0000);
        @(negedge mclk_in);
        chk(16'(unsupported_out), 16'h0000);
    endtask

    // Main sequence
    initial begin
        mclk_in       = 1'b0;
        reset_in      = 1'b1;
        word_valid_in = 1'b0;
        word_in       = 16'h0000;
        error_cnt     = 0;
        n_compared    = 0;
        repeat (20) @(negedge mclk_in);
        reset_in = 1'b0;
        chk(16'(op_class_out), 16'(dsp_decode_pkg::OPC_NONE));
        chk(16'(cycles_out), 16'h0000);
        t_mov();
        t_acc();
        t_mul_ptr();
        t_mul_dir();
        t_msu();
        t_limm();
        t_shift();
        t_unsup();
        repeat (2) @(negedge mclk_in);
        end_sim();
    end

    // Watchdog: the tests need under a hundred cycles
    initial begin
        #(2000 * 25);
        error_cnt++;
        end_sim();
    end
endmodule // test_dsp_multiply_move_decoder
